// File: tcp_regs.svh
/*
 * Register offsets, field positions, reset values, character codes and
 * timing counts of the tablet command parser.
 * Assumes a 20 MHz pclk and a 32-bit APB with byte addresses in paddr.
 */
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

`define TCP_ADDR_CHAR 8'h00
`define TCP_ADDR_STATUS 8'h04
`define TCP_ADDR_BEEP 8'h08
`define TCP_ADDR_POINTS1 8'h0C
`define TCP_ADDR_POINTS2 8'h10
`define TCP_ADDR_CONFIG 8'h14
`define TCP_ADDR_MASKS 8'h18
`define TCP_ADDR_COORD 8'h1C

`define TCP_CHAR_EOI_BIT 8

`define TCP_CH_LF 8'h0A
`define TCP_CH_CR 8'h0D
`define TCP_CH_SPACE 8'h20
`define TCP_CH_COMMA 8'h2C
`define TCP_CH_SEMI 8'h3B
`define TCP_CH_ZERO 8'h30
`define TCP_CH_NINE 8'h39
`define TCP_CH_UP_A 8'h41
`define TCP_CH_UP_Z 8'h5A
`define TCP_CH_LO_A 8'h61
`define TCP_CH_LO_Z 8'h7A
`define TCP_CASE_MASK 8'hDF

`define TCP_CMD_BEEP 16'h4250
`define TCP_CMD_CONT 16'h434E
`define TCP_CMD_SW_TOGGLE 16'h534E
`define TCP_CMD_SW_FOLLOW 16'h5346
`define TCP_CMD_RATE 16'h4352
`define TCP_CMD_DEFAULT 16'h4446
`define TCP_CMD_POINT 16'h4450
`define TCP_CMD_SINGLE 16'h5347
`define TCP_CMD_INPUT_PTS 16'h4950
`define TCP_CMD_OUTPUT_PT 16'h4F44
`define TCP_CMD_MASK 16'h494D
`define TCP_CMD_CLEAR 16'h4443

`define TCP_BEEP_FREQ_DEF 8'h0C
`define TCP_BEEP_DUR_DEF 16'h0096
`define TCP_BEEP_AMP_DEF 3'h4
`define TCP_NOTE_MAX 8'h30
`define TCP_DUR_MAX 16'h7FFF
`define TCP_AMP_MAX 16'h0005
`define TCP_BYTE_MAX 16'h00FF
`define TCP_MASK_MAX 16'h07FF
`define TCP_P1X_DEF 16'h0190
`define TCP_P1Y_DEF 16'h0190
`define TCP_P2X_DEF 16'h2D70
`define TCP_P2Y_DEF 16'h2094
`define TCP_RATE_DEF 6'h3C
`define TCP_EMASK_DEF 8'h07
`define TCP_SMASK_DEF 11'h000
`define TCP_PMASK_DEF 11'h000

`define TCP_ST_POINT 2
`define TCP_ST_INIT 3
`define TCP_ST_READY 4
`define TCP_ST_ERROR 5
`define TCP_ST_PEN 10

`define TCP_ERR_UNKNOWN 8'h01
`define TCP_ERR_NPARAM 8'h02
`define TCP_ERR_VALUE 8'h04

`define TCP_CLK_PERIOD_NS 50
`define TCP_MS_NS 1000000
`define TCP_MS_CYCLES (`TCP_MS_NS / `TCP_CLK_PERIOD_NS)
`define TCP_CLK_HZ (1000000000 / `TCP_CLK_PERIOD_NS)

`endif

// File: tcp_pkg.sv
/*
 * Types shared by the tablet command parser files.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package tcp_pkg;
  typedef enum logic [1:0] {TCP_WAIT_FIRST, TCP_WAIT_SECOND, TCP_ARGS, TCP_SKIP} tcp_parse_t;
  typedef enum logic [1:0] {TCP_DIG_NONE, TCP_DIG_CONT, TCP_DIG_SINGLE, TCP_DIG_POINT} tcp_dig_t;
endpackage

// File: tcp_tick_gen.sv
/*
 * Phase accumulator that emits one-cycle ticks at step/MODULUS of pclk.
 * Assumes step stays well below MODULUS.
 */
`timescale 1ns/100ps
module tcp_tick_gen #(
  parameter int unsigned MODULUS = 1000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Rate control.
  input wire logic [31:0] step,
  output logic tick
);
  logic [31:0] acc_reg;
  logic [32:0] sum;

  assign sum = {1'b0, acc_reg} + {1'b0, step};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0;
      tick <= 1'b0;
    end else if (sum >= 33'(MODULUS)) begin
      acc_reg <= 32'(sum - 33'(MODULUS));
      tick <= 1'b1;
    end else begin
      acc_reg <= sum[31:0];
      tick <= 1'b0;
    end
  end
endmodule

// File: tcp_tone_timer.sv
/*
 * Tone generator control: sets note and level and holds the tone active for a number of milliseconds.
 * Assumes a one-cycle start pulse and a one-cycle millisecond tick.
 */
`include "tcp_regs.svh"
`timescale 1ns/100ps
module tcp_tone_timer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request.
  input wire logic start,
  input wire logic ms_tick,
  input wire logic [7:0] freq,
  input wire logic [15:0] dur,
  input wire logic [2:0] amp,
  // Tone drive.
  output logic active,
  output logic [5:0] note,
  output logic [2:0] level
);
  logic [15:0] left_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 16'h0000;
      active <= 1'b0;
      note <= 6'h00;
      level <= 3'h0;
    end else if (start) begin
      left_reg <= dur;
      // Amplitude zero runs the timer silently, so the tone line stays low.
      active <= (amp != 3'h0) && (dur != 16'h0000);
      note <= (freq > `TCP_NOTE_MAX) ? 6'(`TCP_NOTE_MAX) : freq[5:0];
      level <= amp;
    end else if (ms_tick && left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
      if (left_reg == 16'h0001) begin
        active <= 1'b0;
      end
    end
  end
endmodule

// File: tcp_top.sv
/*
 * Tablet command parser: takes instruction characters written over APB,
 * splits them into two-letter commands with comma-placed parameters and
 * runs the beep, digitizing, rate, points and default-state settings.
 * Assumes the bus interface writes one received byte per APB write, with
 * the end-or-identify flag beside it, and that stylus inputs are synchronous.
 */
`include "tcp_regs.svh"
`timescale 1ns/100ps
module tcp_top
  import tcp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `TCP_MS_CYCLES,
  parameter int unsigned CLK_HZ = `TCP_CLK_HZ
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stylus.
  input wire logic stylus_switch,
  input wire logic [15:0] pen_x,
  input wire logic [15:0] pen_y,
  // Indicators and tone.
  output logic digitize_led,
  output logic point_ready,
  output logic tone_active,
  output logic [5:0] tone_note,
  output logic [2:0] tone_level
);
  tcp_parse_t st_reg, st_next;
  tcp_dig_t mode_reg;
  logic [7:0] letter_reg, letter_next, ch, up;
  logic [15:0] cmd_reg, cmd_next, acc_reg, acc_next;
  logic [19:0] prod;
  logic seen_reg, seen_next;
  logic [2:0] commas_reg, commas_next, max_commas;
  logic [3:0][15:0] vals_reg, vals_next, fin_vals;
  logic [3:0] pres_reg, pres_next, fin_pres;
  logic is_letter, is_digit, is_blank, is_term, term, wr_char, access, setup;
  logic exec, known, too_many, val_bad, cmd_ok, bare, no_args;
  logic [7:0] beep_freq_reg, emask_reg, err_reg;
  logic [15:0] beep_dur_reg, x_reg, y_reg;
  logic [2:0] beep_amp_reg;
  logic [3:0][15:0] pts_reg;
  logic [5:0] rate_reg;
  logic [10:0] smask_reg, pmask_reg, status_word;
  logic beep_go_reg, follow_reg, run_reg, sw_prev_reg, init_reg, menu_on_reg;
  logic press, ms_tick, rate_tick, capture, clear_pt;
  logic [31:0] rd_value;
  logic rd_hit;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_char = access && pwrite && (paddr == `TCP_ADDR_CHAR);
  assign ch = pwdata[7:0];
  assign is_letter = (ch >= `TCP_CH_UP_A && ch <= `TCP_CH_UP_Z)
                     || (ch >= `TCP_CH_LO_A && ch <= `TCP_CH_LO_Z);
  assign up = ch & `TCP_CASE_MASK;
  assign is_digit = ch >= `TCP_CH_ZERO && ch <= `TCP_CH_NINE;
  assign is_blank = ch == `TCP_CH_SPACE || ch == `TCP_CH_CR;
  assign is_term = ch == `TCP_CH_LF || ch == `TCP_CH_SEMI;
  assign term = is_term || pwdata[`TCP_CHAR_EOI_BIT];

  always_comb begin
    st_next = st_reg;
    letter_next = letter_reg;
    cmd_next = cmd_reg;
    acc_next = acc_reg;
    seen_next = seen_reg;
    commas_next = commas_reg;
    vals_next = vals_reg;
    pres_next = pres_reg;
    prod = 20'h00000;
    if (!is_term && !is_blank) begin
      case (st_reg)
        TCP_WAIT_FIRST: begin
          letter_next = up;
          st_next = is_letter ? TCP_WAIT_SECOND : TCP_SKIP;
        end
        TCP_WAIT_SECOND: begin
          cmd_next = {letter_reg, up};
          st_next = is_letter ? TCP_ARGS : TCP_SKIP;
          acc_next = 16'h0000;
          seen_next = 1'b0;
          commas_next = 3'h0;
          pres_next = 4'h0;
        end
        TCP_ARGS: begin
          if (is_digit) begin
            prod = {4'h0, acc_reg} * 20'h0000A + {16'h0000, ch[3:0]};
            acc_next = (prod > 20'h0FFFF) ? 16'hFFFF : prod[15:0];
            seen_next = 1'b1;
          end else if (ch == `TCP_CH_COMMA) begin
            if (commas_reg != 3'h4) begin
              if (seen_reg) begin
                vals_next[commas_reg[1:0]] = acc_reg;
                pres_next[commas_reg[1:0]] = 1'b1;
              end
              commas_next = commas_reg + 3'h1;
              acc_next = 16'h0000;
              seen_next = 1'b0;
            end
          end else begin
            st_next = TCP_SKIP;
          end
        end
        default: begin
          st_next = TCP_SKIP;
        end
      endcase
    end
    fin_vals = vals_next;
    fin_pres = pres_next;
    if (seen_next && commas_next != 3'h4) begin
      fin_vals[commas_next[1:0]] = acc_next;
      fin_pres[commas_next[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= TCP_WAIT_FIRST;
      letter_reg <= 8'h00;
      cmd_reg <= 16'h0000;
      acc_reg <= 16'h0000;
      seen_reg <= 1'b0;
      commas_reg <= 3'h0;
      vals_reg <= '0;
      pres_reg <= 4'h0;
    end else if (wr_char) begin
      st_reg <= term ? TCP_WAIT_FIRST : st_next;
      letter_reg <= letter_next;
      cmd_reg <= cmd_next;
      acc_reg <= acc_next;
      seen_reg <= seen_next;
      commas_reg <= commas_next;
      vals_reg <= vals_next;
      pres_reg <= pres_next;
    end
  end

  assign exec = wr_char && term && st_next == TCP_ARGS;
  assign bare = commas_next == 3'h0 && fin_pres == 4'h0;

  always_comb begin
    known = 1'b1;
    max_commas = 3'h0;
    val_bad = 1'b0;
    no_args = 1'b0;
    case (cmd_next)
      `TCP_CMD_BEEP: begin
        max_commas = 3'h2;
        val_bad = (fin_pres[0] && fin_vals[0] > `TCP_BYTE_MAX)
                  || (fin_pres[1] && (fin_vals[1] == 16'h0000 || fin_vals[1] > `TCP_DUR_MAX))
                  || (fin_pres[2] && fin_vals[2] > `TCP_AMP_MAX);
      end
      `TCP_CMD_CONT: max_commas = 3'h1;
      `TCP_CMD_RATE: begin
        val_bad = fin_pres[0] && (fin_vals[0] == 16'h0000 || fin_vals[0] > 16'(`TCP_RATE_DEF));
      end
      `TCP_CMD_INPUT_PTS: max_commas = 3'h3;
      `TCP_CMD_MASK: begin
        max_commas = 3'h2;
        val_bad = (fin_pres[0] && fin_vals[0] > `TCP_BYTE_MAX)
                  || (fin_pres[1] && fin_vals[1] > `TCP_MASK_MAX)
                  || (fin_pres[2] && fin_vals[2] > `TCP_MASK_MAX);
      end
      `TCP_CMD_SW_TOGGLE, `TCP_CMD_SW_FOLLOW, `TCP_CMD_DEFAULT, `TCP_CMD_POINT,
      `TCP_CMD_SINGLE, `TCP_CMD_OUTPUT_PT, `TCP_CMD_CLEAR: no_args = 1'b1;
      default: known = 1'b0;
    endcase
    too_many = commas_next > max_commas || (no_args && fin_pres != 4'h0);
  end

  assign cmd_ok = exec && known && !too_many && !val_bad;

  // Errors accumulate until the default command; reads never clear them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 8'h00;
    end else if (cmd_ok && cmd_next == `TCP_CMD_DEFAULT) begin
      err_reg <= 8'h00;
    end else if (wr_char && term && (st_next == TCP_WAIT_SECOND || st_next == TCP_SKIP)) begin
      err_reg <= err_reg | `TCP_ERR_UNKNOWN;
    end else if (exec) begin
      if (!known || (cmd_ok && cmd_next == `TCP_CMD_OUTPUT_PT && mode_reg == TCP_DIG_NONE)) begin
        err_reg <= err_reg | `TCP_ERR_UNKNOWN;
      end else if (too_many) begin
        err_reg <= err_reg | `TCP_ERR_NPARAM;
      end else if (val_bad) begin
        err_reg <= err_reg | `TCP_ERR_VALUE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beep_freq_reg <= `TCP_BEEP_FREQ_DEF;
      beep_dur_reg <= `TCP_BEEP_DUR_DEF;
      beep_amp_reg <= `TCP_BEEP_AMP_DEF;
      beep_go_reg <= 1'b0;
    end else begin
      beep_go_reg <= cmd_ok && cmd_next == `TCP_CMD_BEEP;
      if (cmd_ok && cmd_next == `TCP_CMD_BEEP) begin
        if (fin_pres[0]) beep_freq_reg <= fin_vals[0][7:0];
        if (fin_pres[1]) beep_dur_reg <= fin_vals[1];
        if (fin_pres[2]) beep_amp_reg <= fin_vals[2][2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pts_reg <= {`TCP_P2Y_DEF, `TCP_P2X_DEF, `TCP_P1Y_DEF, `TCP_P1X_DEF};
    end else if (cmd_ok && cmd_next == `TCP_CMD_INPUT_PTS) begin
      if (bare) begin
        pts_reg <= {`TCP_P2Y_DEF, `TCP_P2X_DEF, `TCP_P1Y_DEF, `TCP_P1X_DEF};
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (fin_pres[i]) pts_reg[i] <= fin_vals[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= `TCP_RATE_DEF;
      emask_reg <= `TCP_EMASK_DEF;
      smask_reg <= `TCP_SMASK_DEF;
      pmask_reg <= `TCP_PMASK_DEF;
      menu_on_reg <= 1'b1;
      init_reg <= 1'b1;
    end else if (cmd_ok && cmd_next == `TCP_CMD_DEFAULT) begin
      rate_reg <= `TCP_RATE_DEF;
      emask_reg <= `TCP_EMASK_DEF;
      smask_reg <= `TCP_SMASK_DEF;
      pmask_reg <= `TCP_PMASK_DEF;
      menu_on_reg <= 1'b1;
      init_reg <= 1'b0;
    end else if (cmd_ok && cmd_next == `TCP_CMD_RATE) begin
      rate_reg <= fin_pres[0] ? fin_vals[0][5:0] : `TCP_RATE_DEF;
    end else if (cmd_ok && cmd_next == `TCP_CMD_MASK) begin
      if (fin_pres[0]) emask_reg <= fin_vals[0][7:0];
      if (fin_pres[1]) smask_reg <= fin_vals[1][10:0];
      if (fin_pres[2]) pmask_reg <= fin_vals[2][10:0];
    end
  end

  assign press = stylus_switch && !sw_prev_reg;
  assign capture = (mode_reg == TCP_DIG_CONT && run_reg && rate_tick)
                   || ((mode_reg == TCP_DIG_POINT || mode_reg == TCP_DIG_SINGLE) && press);
  assign clear_pt = cmd_ok && (cmd_next == `TCP_CMD_CLEAR || cmd_next == `TCP_CMD_DEFAULT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      follow_reg <= 1'b0;
    end else if (cmd_ok && cmd_next == `TCP_CMD_SW_FOLLOW) begin
      follow_reg <= 1'b1;
    end else if (cmd_ok && (cmd_next == `TCP_CMD_SW_TOGGLE || cmd_next == `TCP_CMD_DEFAULT)) begin
      follow_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= TCP_DIG_NONE;
      digitize_led <= 1'b0;
    end else if (clear_pt) begin
      mode_reg <= TCP_DIG_NONE;
      digitize_led <= 1'b0;
    end else if (cmd_ok && cmd_next == `TCP_CMD_CONT) begin
      mode_reg <= TCP_DIG_CONT;
      digitize_led <= 1'b0;
    end else if (cmd_ok && cmd_next == `TCP_CMD_SINGLE) begin
      mode_reg <= TCP_DIG_SINGLE;
      digitize_led <= 1'b0;
    end else if (cmd_ok && cmd_next == `TCP_CMD_POINT
                 && mode_reg != TCP_DIG_CONT && mode_reg != TCP_DIG_SINGLE) begin
      mode_reg <= TCP_DIG_POINT;
      digitize_led <= 1'b1;
    end else if (capture && mode_reg != TCP_DIG_CONT) begin
      mode_reg <= TCP_DIG_NONE;
      digitize_led <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_prev_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      sw_prev_reg <= stylus_switch;
      if (mode_reg != TCP_DIG_CONT || clear_pt) begin
        run_reg <= 1'b0;
      end else if (follow_reg) begin
        run_reg <= stylus_switch;
      end else if (press) begin
        run_reg <= !run_reg;
      end
    end
  end

  // point sets bit 2, winning over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      point_ready <= 1'b0;
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
    end else if (capture) begin
      point_ready <= 1'b1;
      x_reg <= pen_x;
      y_reg <= pen_y;
    end else if (clear_pt) begin
      point_ready <= 1'b0;
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
    end
  end

  assign status_word = {stylus_switch, 4'h0, (err_reg & emask_reg) != 8'h00, 1'b1,
                        init_reg, point_ready, 2'b00};

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      `TCP_ADDR_CHAR: rd_value = {30'h0, st_reg};
      `TCP_ADDR_STATUS: rd_value = {21'h0, status_word};
      `TCP_ADDR_BEEP: rd_value = {5'h0, beep_amp_reg, beep_freq_reg, beep_dur_reg};
      `TCP_ADDR_POINTS1: rd_value = {pts_reg[1], pts_reg[0]};
      `TCP_ADDR_POINTS2: rd_value = {pts_reg[3], pts_reg[2]};
      `TCP_ADDR_CONFIG: rd_value = {err_reg, emask_reg, digitize_led, menu_on_reg, run_reg,
                                    follow_reg, 2'h0, mode_reg, 2'h0, rate_reg};
      `TCP_ADDR_MASKS: rd_value = {5'h0, pmask_reg, 5'h0, smask_reg};
      `TCP_ADDR_COORD: rd_value = {y_reg, x_reg};
      default: begin
        rd_value = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // The answer is prepared in the setup cycle so every bus output is a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && (!rd_hit || (pwrite && paddr != `TCP_ADDR_CHAR));
      prdata <= (setup && !pwrite) ? rd_value : 32'h0;
    end
  end

  tcp_tick_gen #(.MODULUS(MS_CYCLES)) u_ms_tick (
    .pclk(pclk),
    .presetn(presetn),
    .step(32'h1),
    .tick(ms_tick)
  );

  tcp_tick_gen #(.MODULUS(CLK_HZ)) u_rate_tick (
    .pclk(pclk),
    .presetn(presetn),
    .step({26'h0, rate_reg}),
    .tick(rate_tick)
  );

  tcp_tone_timer u_tone (
    .pclk(pclk),
    .presetn(presetn),
    .start(beep_go_reg),
    .ms_tick(ms_tick),
    .freq(beep_freq_reg),
    .dur(beep_dur_reg),
    .amp(beep_amp_reg),
    .active(tone_active),
    .note(tone_note),
    .level(tone_level)
  );
endmodule

// File: tcp_top_properties.sv
/*
 * Concurrent checks on the ports of the tablet command parser.
 * Assumes it is bound to tcp_top and sees only its ports.
 */
`include "tcp_regs.svh"
`timescale 1ns/100ps
module tcp_top_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stylus and indicators.
  input wire logic stylus_switch,
  input wire logic digitize_led,
  input wire logic point_ready,
  input wire logic tone_active,
  input wire logic [5:0] tone_note,
  input wire logic [2:0] tone_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  note_range_a: assert property (tone_note <= 6'h30)
    else $error("note above top pitch");
  level_range_a: assert property (tone_level <= 3'h5)
    else $error("level above loudest");
  led_cause_a: assert property ($rose(digitize_led) |->
    $past(psel && penable && pwrite && paddr == `TCP_ADDR_CHAR))
    else $error("indicator lit without a character");
  point_clear_a: assert property ($fell(point_ready) |->
    $past(psel && penable && pwrite))
    else $error("point flag dropped without a command");
  led_press_a: assert property (digitize_led && stylus_switch &&
    !$past(stylus_switch) |-> ##[1:3] !digitize_led)
    else $error("indicator stays lit after capture");
endmodule

// File: tcp_stylus_model.sv
/*
 * Stylus model: tip switch and a settable pen position.
 * Assumes the bench calls set_tip just after a rising pclk edge.
 */
`timescale 1ns/100ps
module tcp_stylus_model (
  // Clock.
  input wire logic pclk,
  // Stylus.
  output logic tip,
  output logic [15:0] pos_x,
  output logic [15:0] pos_y
);
  initial begin
    tip = 1'b0;
    pos_x = 16'h0000;
    pos_y = 16'h0000;
  end
  // The position moves on a clock edge too, so a capture never sees it half changed.
  task automatic set_pos(input logic [15:0] x, input logic [15:0] y);
    @(posedge pclk);
    pos_x <= x;
    pos_y <= y;
  endtask
  // The switch moves only on a clock edge, as the design samples it as synchronous.
  task automatic set_tip(input logic v);
    @(posedge pclk);
    tip <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// File: tcp_top_tb.sv
/*
 * Self-checking bench of the tablet command parser over APB.
 * Assumes the header, package, design and stylus model are compiled first.
 */
`include "tcp_regs.svh"
`timescale 1ns/100ps
module tcp_top_tb;
  logic pclk = 1'b0;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, tip, led, pt, t_on;
  logic [15:0] px, py;
  logic [5:0] note;
  logic [2:0] lvl;
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  tcp_top #(.MS_CYCLES(20), .CLK_HZ(600)) dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stylus_switch(tip),
    .pen_x(px), .pen_y(py), .digitize_led(led), .point_ready(pt),
    .tone_active(t_on), .tone_note(note), .tone_level(lvl));
  tcp_stylus_model stylus_u (.pclk(pclk), .tip(tip), .pos_x(px), .pos_y(py));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk(q & m, x);
  endtask
  // One character per write; the flag rides on the last one only when asked.
  task automatic send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++) begin
      apb(`TCP_ADDR_CHAR, 1'b1, {23'h0, eoi && i == s.len() - 1, s[i]});
    end
  endtask
  task automatic wait_on(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(`TCP_ADDR_BEEP, 32'hFFFFFFFF, 32'h040C0096);
    rc(`TCP_ADDR_POINTS1, 32'hFFFFFFFF, 32'h01900190);
    rc(`TCP_ADDR_POINTS2, 32'hFFFFFFFF, 32'h20942D70);
    rc(`TCP_ADDR_CONFIG, 32'h00FF333F, 32'h0007003C);
    rc(8'h20, 32'hFFFFFFFF, 32'h0);
    chk(32'(e), 32'h1);
    send("bp 60 , 2 \015;", 1'b0);
    rc(`TCP_ADDR_BEEP, 32'hFFFFFFFF, 32'h043C0002);
    chk({22'h0, t_on, note, lvl}, {22'h0, 1'b1, 6'h30, 3'h4});
    wait_on(t_on, 1'b0, 200);
    send("BP20,,3\n", 1'b0);
    rc(`TCP_ADDR_BEEP, 32'hFFFFFFFF, 32'h03140002);
    chk({22'h0, t_on, note, lvl}, {22'h0, 1'b1, 6'h14, 3'h3});
    wait_on(t_on, 1'b0, 200);
    send("bp,0;BP,,6\n", 1'b0);
    rc(`TCP_ADDR_BEEP, 32'hFFFFFFFF, 32'h03140002);
    rc(`TCP_ADDR_CONFIG, 32'hFF000000, 32'h04000000);
    send("BP,,0\n", 1'b0);
    rc(`TCP_ADDR_BEEP, 32'hFFFFFFFF, 32'h00140002);
    chk({22'h0, t_on, note, lvl}, {22'h0, 1'b0, 6'h14, 3'h0});
    send("IP1,2,3,", 1'b0);
    send("4", 1'b1);
    rc(`TCP_ADDR_POINTS1, 32'hFFFFFFFF, 32'h00020001);
    rc(`TCP_ADDR_POINTS2, 32'hFFFFFFFF, 32'h00040003);
    send("IP,,8000;IP,,,\n", 1'b0);
    rc(`TCP_ADDR_POINTS2, 32'hFFFFFFFF, 32'h00041F40);
    send("IP\n", 1'b0);
    rc(`TCP_ADDR_POINTS1, 32'hFFFFFFFF, 32'h01900190);
    send("CR5;CN1,2\n", 1'b0);
    rc(`TCP_ADDR_CONFIG, 32'h0000333F, 32'h00000105);
    send("CR\nDP\n", 1'b0);
    rc(`TCP_ADDR_CONFIG, 32'h0000333F, 32'h0000013C);
    chk(32'(led), 32'h0);
    stylus_u.set_tip(1'b1);
    rc(`TCP_ADDR_CONFIG, 32'h00003000, 32'h00002000);
    wait_on(pt, 1'b1, 40);
    rc(`TCP_ADDR_STATUS, 32'h00000004, 32'h00000004);
    stylus_u.set_tip(1'b0);
    stylus_u.set_tip(1'b1);
    rc(`TCP_ADDR_CONFIG, 32'h00003000, 32'h00000000);
    stylus_u.set_tip(1'b0);
    send("SF\n", 1'b0);
    stylus_u.set_tip(1'b1);
    rc(`TCP_ADDR_CONFIG, 32'h00003000, 32'h00003000);
    stylus_u.set_tip(1'b0);
    rc(`TCP_ADDR_CONFIG, 32'h00003000, 32'h00001000);
    send("DC\n", 1'b0);
    rc(`TCP_ADDR_CONFIG, 32'h00000300, 32'h0);
    chk(32'(pt), 32'h0);
    stylus_u.set_pos(16'h0123, 16'h0456);
    send("DP\n", 1'b0);
    @(posedge pclk);
    chk(32'(led), 32'h1);
    stylus_u.set_tip(1'b1);
    wait_on(pt, 1'b1, 20);
    chk({30'h0, led, pt}, 32'h1);
    rc(`TCP_ADDR_COORD, 32'hFFFFFFFF, 32'h04560123);
    stylus_u.set_tip(1'b0);
    send("CR5;SN;DF\n", 1'b0);
    rc(`TCP_ADDR_CONFIG, 32'h00FF333F, 32'h0007003C);
    rc(`TCP_ADDR_MASKS, 32'hFFFFFFFF, 32'h0);
    rc(`TCP_ADDR_STATUS, 32'h000007FF, 32'h00000010);
    complete_run();
  end
endmodule
bind tcp_top tcp_top_properties chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stylus_switch(stylus_switch), .digitize_led(digitize_led),
  .point_ready(point_ready), .tone_active(tone_active), .tone_note(tone_note),
  .tone_level(tone_level));
